// >>> design/ucf_host.sv
/*
 ucf_host: host-side controller of a half-duplex 8-N-1 command frame link.
 Software fills command registers over APB, starts a frame or a flush
 break, and reads back the response frame and link status.
 Assumes a 250 MHz sys_clk, the device on the far end of uart_tx/uart_rx,
 and an APB master that keeps psel/penable/paddr stable until pready.
*/
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
module ucf_host
    import ucf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             uart_tx,
    input  wire logic        uart_rx
);
    ucf_state_t  s_r;
    ucf_state_t  s_nxt;
    logic        acc;
    logic        wr_now;
    logic        wr_ctrl;
    logic        go;
    logic        flush;
    logic        do_load;
    logic [3:0]  load_k;
    logic [3:0]  nb;
    logic [3:0]  last_k;
    logic [7:0]  tb;
    logic [7:0]  rb;
    logic        rbyte;
    logic [15:0] rc;
    logic [31:0] rd_word;
    logic        mapped;

    function automatic logic [7:0] tx_byte(input logic [3:0]  k,
                                           input logic [31:0] cmd,
                                           input logic [63:0] dat,
                                           input logic [15:0] crc,
                                           input logic [3:0]  cnt);
        logic [2:0] i;
        i = 3'(k - 4'd4);
        if (k == 4'd0)
            return {1'b1, 2'b00, cmd[CMD_WR], 1'b0,
                    cmd[CMD_WR] ? cmd[2:0] : 3'b000};
        else if (k == 4'd1)
            return {2'b00, cmd[13:8]};
        else if (k == 4'd2)
            return cmd[31:24];
        else if (k == 4'd3)
            return cmd[23:16];
        else if (k < 4'd4 + cnt)
            return dat[{i, 3'b000} +: 8];
        else if (k == 4'd4 + cnt)
            return crc[7:0];
        else
            return crc[15:8];
    endfunction : tx_byte

    // writes carry 1..8 data bytes, a read carries its length byte only
    assign nb     = s_r.cmd[CMD_WR] ? 4'(s_r.cmd[2:0]) + 4'd1
                                    : 4'd1;
    assign last_k = nb + 4'd5;
    assign acc    = psel && penable;
    assign wr_now = acc && s_r.pready_r && pwrite;
    assign wr_ctrl = wr_now && (paddr == OFS_CTRL);
    assign go     = wr_ctrl && pwdata[CTRL_GO];
    assign flush  = wr_ctrl && pwdata[CTRL_FLUSH];

    always_comb
    begin
        mapped  = 1'b1;
        rd_word = 32'h0;
        if (paddr[11:9] == BUF_PAGE && paddr[1:0] == 2'b00)
            rd_word = {24'h0, s_r.rbuf[paddr[8:2]]};
        else
            case (paddr)
                OFS_CTRL: rd_word = 32'h0;
                OFS_CMD:  rd_word = s_r.cmd;
                OFS_DLO:  rd_word = s_r.dat[31:0];
                OFS_DHI:  rd_word = s_r.dat[63:32];
                OFS_STAT: rd_word = {15'h0, s_r.rlvl, s_r.rlen, 3'h0,
                                     s_r.init_err, s_r.stop_err,
                                     s_r.crc_err, s_r.done,
                                     s_r.st != ST_IDLE};
                OFS_HDR:  rd_word = s_r.hdr;
                default:  mapped  = 1'b0;
            endcase
    end

    always_comb
    begin
        s_nxt   = s_r;
        do_load = 1'b0;
        load_k  = 4'd0;
        tb      = 8'h0;
        rb      = 8'h0;
        rbyte   = 1'b0;
        rc      = 16'h0;
        // apb: one wait cycle, then pready with registered data
        s_nxt.pready_r  = acc && !s_r.pready_r;
        s_nxt.pslverr_r = acc && !s_r.pready_r && !mapped;
        if (acc && !s_r.pready_r)
            s_nxt.prdata_r = pwrite ? 32'h0 : rd_word;
        if (wr_now)
            case (paddr)
                OFS_CMD: s_nxt.cmd = pwdata;
                OFS_DLO: s_nxt.dat[31:0] = pwdata;
                OFS_DHI: s_nxt.dat[63:32] = pwdata;
                OFS_STAT:
                begin
                    // write one to clear; a set below still wins
                    s_nxt.done     = s_r.done & ~pwdata[STAT_DONE];
                    s_nxt.crc_err  = s_r.crc_err & ~pwdata[STAT_CRC];
                    s_nxt.stop_err = s_r.stop_err & ~pwdata[STAT_STOP];
                    s_nxt.init_err = s_r.init_err & ~pwdata[STAT_INIT];
                end
                default: ;
            endcase

        // transmit side
        case (s_r.st)
            ST_IDLE:
                if (go)
                begin
                    s_nxt.st   = ST_TXB;
                    s_nxt.tidx = 4'd0;
                    s_nxt.tcrc = CRC_INIT;
                    do_load    = 1'b1;
                    load_k     = 4'd0;
                end
            ST_TXB:
                if (s_r.bcnt == BIT_CYC - 12'd1)
                begin
                    s_nxt.bcnt = 12'd0;
                    if (s_r.bitn == STOP_BITN)
                    begin
                        if (s_r.tidx == last_k)
                        begin
                            // only a read earns a response frame
                            if (s_r.cmd[CMD_WR])
                                s_nxt.st = ST_IDLE;
                            else
                            begin
                                s_nxt.st   = ST_WAITR;
                                s_nxt.ron  = 1'b1;
                                s_nxt.ridx = 8'd0;
                                s_nxt.rcrc = CRC_INIT;
                            end
                        end
                        else
                        begin
                            do_load = 1'b1;
                            load_k  = s_r.tidx + 4'd1;
                        end
                    end
                    else
                    begin
                        s_nxt.sh   = {1'b1, s_r.sh[9:1]};
                        s_nxt.bitn = s_r.bitn + 4'd1;
                    end
                end
                else
                    s_nxt.bcnt = s_r.bcnt + 12'd1;
            ST_BRK:
                if (s_r.bcnt == BRK_CYC - 12'd1)
                begin
                    s_nxt.st   = ST_GAP;
                    s_nxt.bcnt = 12'd0;
                end
                else
                    s_nxt.bcnt = s_r.bcnt + 12'd1;
            ST_GAP:
                if (s_r.bcnt == GAP_CYC - 12'd1)
                    s_nxt.st = ST_IDLE;
                else
                    s_nxt.bcnt = s_r.bcnt + 12'd1;
            ST_WAITR: ;
            default: s_nxt.st = ST_IDLE;
        endcase

        if (do_load)
        begin
            tb = tx_byte(load_k, s_r.cmd, s_r.dat, s_nxt.tcrc, nb);
            s_nxt.tidx = load_k;
            s_nxt.sh   = {1'b1, tb, 1'b0};
            s_nxt.bitn = 4'd0;
            s_nxt.bcnt = 12'd0;
            if (load_k < 4'd4 + nb)
                s_nxt.tcrc = ucf_crc_byte(s_nxt.tcrc, tb);
        end

        // receive side: three stages, a change counts once two agree
        s_nxt.rs1 = uart_rx;
        s_nxt.rs2 = s_r.rs1;
        s_nxt.rs3 = s_r.rs2;
        if (s_r.rs2 == s_r.rs3)
            s_nxt.rlvl = s_r.rs3;
        case (s_r.rph)
            RX_IDLE:
                if (!s_r.rlvl)
                begin
                    s_nxt.rph  = RX_START;
                    s_nxt.rcnt = 12'd0;
                end
            RX_START:
                if (s_r.rcnt == HALF_CYC - 12'd1)
                begin
                    s_nxt.rph  = s_r.rlvl ? RX_IDLE : RX_DATA;
                    s_nxt.rcnt = 12'd0;
                    s_nxt.rbit = 4'd0;
                end
                else
                    s_nxt.rcnt = s_r.rcnt + 12'd1;
            RX_DATA:
                if (s_r.rcnt == BIT_CYC - 12'd1)
                begin
                    s_nxt.rcnt = 12'd0;
                    if (s_r.rbit == MSB_BITN)
                    begin
                        if (!s_r.rlvl)
                            s_nxt.stop_err = 1'b1;
                        rbyte     = 1'b1;
                        rb        = s_r.rsh;
                        s_nxt.rph = RX_END;
                    end
                    else
                    begin
                        s_nxt.rsh  = {s_r.rlvl, s_r.rsh[7:1]};
                        s_nxt.rbit = s_r.rbit + 4'd1;
                    end
                end
                else
                    s_nxt.rcnt = s_r.rcnt + 12'd1;
            RX_END:
                // a line held low after the stop bit keeps us here until it goes high
                if (s_r.rlvl)
                    s_nxt.rph = RX_IDLE;
            default: s_nxt.rph = RX_IDLE;
        endcase

        if (rbyte && s_r.ron)
        begin
            rc         = ucf_crc_byte(s_r.rcrc, rb);
            s_nxt.rcrc = rc;
            s_nxt.ridx = s_r.ridx + 8'd1;
            if (s_r.ridx == 8'd0)
            begin
                s_nxt.hdr[31:24] = rb;
                s_nxt.rlen = {1'b0, rb[6:0]} + 8'd1;
                if (rb[7])
                    s_nxt.init_err = 1'b1;
            end
            else if (s_r.ridx < 8'd4)
                s_nxt.hdr[8'd31 - {s_r.ridx, 3'b000} -: 8] = rb;
            else if (s_r.ridx < s_r.rlen + 8'd4)
                s_nxt.rbuf[7'(s_r.ridx - 8'd4)] = rb;
            if (s_r.ridx != 8'd0 && s_r.ridx == s_r.rlen + 8'd5)
            begin
                s_nxt.ron  = 1'b0;
                s_nxt.st   = ST_IDLE;
                s_nxt.done = 1'b1;
                if (rc != 16'h0)
                    s_nxt.crc_err = 1'b1;
            end
        end

        // a break preempts anything, including a pending response
        if (flush)
        begin
            s_nxt.st   = ST_BRK;
            s_nxt.bcnt = 12'd0;
            s_nxt.ron  = 1'b0;
        end
        s_nxt.tx_r = (s_nxt.st == ST_TXB) ? s_nxt.sh[0]
                                          : (s_nxt.st != ST_BRK);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r      <= '0;
            s_r.tx_r <= 1'b1;
            s_r.sh   <= 10'h3ff;
            s_r.rs1  <= 1'b1;
            s_r.rs2  <= 1'b1;
            s_r.rs3  <= 1'b1;
            s_r.rlvl <= 1'b1;
        end
        else if (ce)
            s_r <= s_nxt;
    end

    assign pready  = s_r.pready_r;
    assign prdata  = s_r.prdata_r;
    assign pslverr = s_r.pslverr_r;
    assign uart_tx = s_r.tx_r;

    // checks assume ce held high; they pause while it is low
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !ce);

    idle_line_a: assert property (
        s_r.st == ST_IDLE |-> s_r.tx_r)
        else $error("tx line not high while idle");
    start_low_a: assert property (
        (s_r.st == ST_IDLE && go && !flush)
        |=> (!s_r.tx_r && s_r.st == ST_TXB))
        else $error("frame did not open with a low start bit");
    bit_hold_a: assert property (
        (s_r.st == ST_TXB && s_r.bcnt != 12'd0) |-> $stable(s_r.tx_r))
        else $error("tx changed inside a bit period");
    stop_high_a: assert property (
        (s_r.st == ST_TXB && s_r.bitn == STOP_BITN) |-> s_r.tx_r)
        else $error("stop bit not high");
    init_kind_a: assert property (
        (s_r.st == ST_TXB && s_r.tidx == 4'd0 && s_r.bitn == MSB_BITN)
        |-> s_r.tx_r)
        else $error("command init bit7 not one");
    brk_low_a: assert property (
        s_r.st == ST_BRK |-> (!s_r.tx_r && s_r.bcnt < BRK_CYC))
        else $error("break not low or too long");
    flush_now_a: assert property (
        flush |=> (s_r.st == ST_BRK && !s_r.ron))
        else $error("flush break not started at once");
    busy_go_a: assert property (
        (s_r.st == ST_WAITR && go && !flush) |=> s_r.st == ST_WAITR)
        else $error("command started while awaiting response");
    stop_flag_a: assert property (
        (s_r.rph == RX_DATA && s_r.rbit == MSB_BITN &&
         s_r.rcnt == BIT_CYC - 12'd1 && !s_r.rlvl) |=> s_r.stop_err)
        else $error("missing stop bit not flagged");
    apb_wait_a: assert property (
        (acc && !s_r.pready_r) |=> (s_r.pready_r ##1 !s_r.pready_r))
        else $error("apb answer not after one wait cycle");

    write_frame_c: cover property (
        s_r.st == ST_TXB && s_r.cmd[CMD_WR] ##1 s_r.st == ST_IDLE);
    read_done_c: cover property ($rose(s_r.done) && !s_r.crc_err);
    crc_bad_c: cover property ($rose(s_r.crc_err));
    flush_c: cover property (s_r.st == ST_GAP ##1 s_r.st == ST_IDLE);
endmodule : ucf_host

// >>> inc/ucf_pkg.sv
/*
 ucf_pkg: constants, types and the frame check function of the host-side
 command frame port. Assumes a 250 MHz system clock and a 1 Mbps link.
*/
package ucf_pkg;
    localparam int CLK_NS   = 4;
    localparam int BIT_NS   = 1000;
    localparam int BRK_BITS = 15;
    localparam int GAP_BITS = 2;
    localparam logic [11:0] BIT_CYC  = 12'(BIT_NS / CLK_NS);
    localparam logic [11:0] HALF_CYC = 12'(BIT_NS / CLK_NS / 2);
    localparam logic [11:0] BRK_CYC  = 12'(BRK_BITS * BIT_NS / CLK_NS);
    localparam logic [11:0] GAP_CYC  = 12'(GAP_BITS * BIT_NS / CLK_NS);
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMD  = 12'h004;
    localparam logic [11:0] OFS_DLO  = 12'h008;
    localparam logic [11:0] OFS_DHI  = 12'h00c;
    localparam logic [11:0] OFS_STAT = 12'h010;
    localparam logic [11:0] OFS_HDR  = 12'h014;
    localparam logic [2:0]  BUF_PAGE = 3'h1;
    localparam int CTRL_GO    = 0;
    localparam int CTRL_FLUSH = 1;
    localparam int CMD_WR     = 4;
    localparam int STAT_DONE  = 1;
    localparam int STAT_CRC   = 2;
    localparam int STAT_STOP  = 3;
    localparam int STAT_INIT  = 4;
    localparam logic [3:0] STOP_BITN = 4'h9;
    localparam logic [3:0] MSB_BITN  = 4'h8;

    typedef enum logic [2:0] {ST_IDLE, ST_TXB, ST_BRK, ST_GAP, ST_WAITR}
        ucf_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_END} ucf_rph_t;

    typedef struct packed {
        ucf_st_t          st;
        logic             tx_r;
        logic [9:0]       sh;
        logic [11:0]      bcnt;
        logic [3:0]       bitn;
        logic [3:0]       tidx;
        logic [15:0]      tcrc;
        logic             rs1;
        logic             rs2;
        logic             rs3;
        logic             rlvl;
        ucf_rph_t         rph;
        logic [11:0]      rcnt;
        logic [3:0]       rbit;
        logic [7:0]       rsh;
        logic [7:0]       ridx;
        logic [7:0]       rlen;
        logic [15:0]      rcrc;
        logic             ron;
        logic [31:0]      cmd;
        logic [63:0]      dat;
        logic [31:0]      hdr;
        logic             done;
        logic             crc_err;
        logic             stop_err;
        logic             init_err;
        logic [127:0][7:0] rbuf;
        logic             pready_r;
        logic             pslverr_r;
        logic [31:0]      prdata_r;
    } ucf_state_t;

    function automatic logic [15:0] ucf_crc_byte(input logic [15:0] c,
                                                 input logic [7:0]  b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction : ucf_crc_byte
endpackage : ucf_pkg

// >>> bench/ucf_dev_model.sv
/*
 ucf_dev_model: behavioural device at the far end of the frame link.
 Assumes 1 Mbps 8-N-1 lines that idle high, driven by the host port.
*/
`timescale 1ns/100ps
module ucf_dev_model #(
    parameter logic [5:0] NODE0    = 6'h2a,
    parameter logic [5:0] NODE1    = 6'h15,
    parameter int         HOLD     = 1,
    parameter bit         TWO_STOP = 1'b0
) (
    input  wire logic       rx,
    input  wire logic       dir_sel,
    input  wire logic       spoil,
    output logic            tx,
    output logic            flush_seen,
    output logic            stop_seen,
    output logic [7:0]      frames
);
    localparam int BT = 1000;
    logic [7:0]  mem [256];
    logic [7:0]  f [$];
    logic [7:0]  r [$];
    logic [7:0]  b;
    logic        s;
    logic [15:0] c;
    logic [15:0] a;
    int          n;

    function automatic logic [15:0] crc8(input logic [15:0] x,
                                         input logic [7:0]  d);
        for (int i = 0; i < 8; i++)
            x = (x[0] ^ d[i]) ? ((x >> 1) ^ 16'ha001) : (x >> 1);
        return x;
    endfunction : crc8

    task automatic get_byte(output logic [7:0] d, output logic stp);
        @(negedge rx);
        #(BT / 2);
        for (int i = 0; i < 8; i++)
        begin
            #BT;
            d[i] = rx;
        end
        #BT;
        stp = rx;
    endtask : get_byte

    task automatic put_byte(input logic [7:0] d, input logic low_stop);
        tx = 1'b0;
        #BT;
        for (int i = 0; i < 8; i++)
        begin
            tx = d[i];
            #BT;
        end
        tx = ~low_stop;
        #BT;
        tx = 1'b1;
        if (TWO_STOP)
            #BT;
    endtask : put_byte

    // one process: nothing is heard on rx while a response goes out
    task automatic take_frame();
        c = 16'hffff;
        foreach (f[i])
            c = crc8(c, f[i]);
        a = {f[2], f[3]};
        if (c != 16'h0 || !f[0][7] ||
            f[1] != {2'b00, dir_sel ? NODE1 : NODE0})
            return;
        frames = frames + 8'h01;
        if (f[0][6:4] == 3'b001)
        begin
            for (int i = 0; i <= f[0][2:0]; i++)
                if (a + i < 16'h100)
                    mem[8'(a + i)] = f[4 + i];
        end
        else if (f[0][6:4] == 3'b000)
        begin
            #(HOLD * BT);
            r = {f[4] & 8'h7f, f[1], f[2], f[3]};
            for (int i = 0; i <= f[4][6:0]; i++)
                r.push_back((a + i < 16'h100) ? mem[8'(a + i)] : 8'h00);
            c = 16'hffff;
            foreach (r[i])
                c = crc8(c, r[i]);
            r.push_back(c[7:0] ^ {7'h0, spoil});
            r.push_back(c[15:8]);
            foreach (r[i])
                put_byte(r[i], spoil && i == r.size() - 1);
        end
    endtask : take_frame

    initial
    begin
        tx = 1'b1;
        flush_seen = 1'b0;
        stop_seen = 1'b0;
        frames = 8'h00;
        foreach (mem[i])
            mem[i] = 8'h00;
        forever
        begin
            get_byte(b, s);
            if (!s)
            begin
                stop_seen = 1'b1;
                n = 0;
                while (rx === 1'b0 && n < 40)
                begin
                    #BT;
                    n++;
                end
                if (n > 1)
                begin
                    flush_seen = 1'b1;
                    f.delete();
                    continue;
                end
            end
            f.push_back(b);
            if (f.size() == ((f[0][6:4] == 3'b001) ? 7 + f[0][2:0] : 7))
            begin
                take_frame();
                f.delete();
            end
        end
    end
endmodule : ucf_dev_model

// >>> bench/uart_command_frame_port_test.sv
/*
 uart_command_frame_port_test: drives the host port over APB against the
 device model. Assumes ucf_pkg offsets and a 250 MHz clock.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("[FAIL] %s expected %h seen %h", nm, e, g); \
        end \
    end
module uart_command_frame_port_test import ucf_pkg::*;;
    typedef struct packed {
        logic        wr;
        logic [15:0] ra;
        logic [2:0]  cnt;
        logic [31:0] dlo;
        logic [7:0]  exp0;
    } ucf_row_t;
    localparam logic [5:0] NODE = 6'h2a;
    // one byte written at the last mapped register, then read back
    ucf_row_t rows [2] = '{'{1'b1, 16'h00ff, 3'h0, 32'h0000_00c3, 8'h00},
                           '{1'b0, 16'h00ff, 3'h0, 32'h0000_0000, 8'hc3}};
    logic        sys_clk;
    logic        rst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        uart_tx;
    logic        uart_rx;
    logic        dir_sel;
    logic        spoil;
    logic        flush_seen;
    logic        stop_seen;
    logic [7:0]  frames;
    logic [31:0] rdata;
    logic        rerr;
    int          checks = 0;
    int          mismatches = 0;
    int          cycles = 0;

    ucf_host dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .uart_tx(uart_tx), .uart_rx(uart_rx));
    ucf_dev_model #(.NODE0(NODE)) dev (.rx(uart_tx), .dir_sel(dir_sel),
        .spoil(spoil), .tx(uart_rx), .flush_seen(flush_seen),
        .stop_seen(stop_seen), .frames(frames));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // entered just after a rising edge; leaves one idle edge behind
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // exactly one wait cycle is expected and checked below; only the bench timeout ends a stalled wait
        while (pready !== 1'b1)
        begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("apb wait", 1, n);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic wait_idle();
        int n;
        n = 0;
        rdata = 32'h1;
        while (rdata[0] !== 1'b0 && n < 12000)
        begin
            apb(1'b0, OFS_STAT, 32'h0);
            n++;
        end
        `CHK("busy", 1'b0, rdata[0]);
    endtask : wait_idle

    task automatic run(input ucf_row_t rw);
        apb(1'b1, OFS_CMD, {rw.ra, 2'b00, NODE, 3'b000, rw.wr, 1'b0, rw.cnt});
        apb(1'b1, OFS_DLO, rw.dlo);
        apb(1'b1, OFS_CTRL, 32'h1);
    endtask : run

    always #2 sys_clk = ~sys_clk;

    // the whole run needs about 110k cycles, mostly bytes on the wire
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 140000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        dir_sel = 1'b0;
        spoil = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        `CHK("tx idle", 1'b1, uart_tx);
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("stat reset", 16'h0000, rdata[15:0]);
        apb(1'b0, 12'h0f0, 32'h0);
        `CHK("unmapped", 1'b1, rerr);
        $display("test reset done");
        foreach (rows[i])
        begin
            run(rows[i]);
            wait_idle();
            if (!rows[i].wr)
            begin
                apb(1'b0, OFS_HDR, 32'h0);
                `CHK("header", {10'h0, NODE, rows[i].ra}, rdata);
                apb(1'b0, 12'h200, 32'h0);
                `CHK("data", rows[i].exp0, rdata[7:0]);
            end
            $display("test row %0d done", i);
        end
        `CHK("frames", 8'h02, frames);
        dir_sel <= 1'b1;
        run(rows[0]);
        wait_idle();
        `CHK("frames", 8'h02, frames);
        dir_sel <= 1'b0;
        $display("test direction done");
        run(rows[1]);
        apb(1'b1, OFS_CTRL, 32'h2);
        // a frozen clock enable must stretch the break by the frozen time
        ce <= 1'b0;
        repeat (500) @(posedge sys_clk);
        ce <= 1'b1;
        repeat (3500) @(posedge sys_clk);
        `CHK("freeze", 1'b0, uart_tx);
        wait_idle();
        `CHK("flush flag", 1'b1, flush_seen);
        `CHK("stop flag", 1'b1, stop_seen);
        apb(1'b1, OFS_STAT, 32'h1e);
        $display("test flush done");
        spoil <= 1'b1;
        run(rows[1]);
        wait_idle();
        `CHK("faults", 4'h7, rdata[4:1]);
        `CHK("frames", 8'h03, frames);
        apb(1'b1, OFS_STAT, 32'h1e);
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("cleared", 4'h0, rdata[4:1]);
        $display("test faults done");
        wrap_up();
    end
endmodule : uart_command_frame_port_test
